// File: rtl/ofe_datapath.sv
// Operand-format datapath and effective-address calculator
`timescale 1ns/1ps
module ofe_datapath
  import ofe_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Effective-address request
  input  wire logic             ea_start_i,
  input  wire ofe_mode_e        ea_mode_i,
  input  wire ofe_size_e        ea_opsize_i,
  input  wire logic             ea_pc_rel_i,
  input  wire logic [31:0]      ea_base_i,
  input  wire logic [31:0]      ea_pc_i,
  input  wire logic [31:0]      ea_index_i,
  input  wire logic             ea_index_long_i,
  input  wire logic [1:0]       ea_scale_i,
  input  wire logic             ea_index_sup_i,
  input  wire logic [31:0]      ea_disp_i,
  input  wire logic [1:0]       ea_disp_sz_i,
  input  wire logic [31:0]      ea_outer_i,
  input  wire logic [1:0]       ea_outer_sz_i,
  input  wire logic [31:0]      ea_ext_word_i,
  output logic                  ea_busy_o,
  output logic                  ea_done_o,
  output logic [31:0]           ea_addr_o,
  output logic [31:0]           ea_base_new_o,
  output logic                  ea_base_wr_o,
  output logic [31:0]           ea_imm_o,
  output logic                  ea_align_err_o,
  // Long-word memory read and write port
  output logic                  mem_req_o,
  output logic                  mem_we_o,
  output logic [31:0]           mem_addr_o,
  output logic [31:0]           mem_wdata_o,
  input  wire logic             mem_ack_i,
  input  wire logic [31:0]      mem_rdata_i,
  // Block move request
  input  wire logic             blk_start_i,
  input  wire logic [31:0]      blk_src_i,
  input  wire logic [31:0]      blk_dst_i,
  output logic                  blk_done_o,
  // Integer to extended conversion
  input  wire logic [31:0]      cvt_int_i,
  input  wire ofe_size_e        cvt_size_i,
  output logic [EXT_USED_W-1:0] cvt_ext_o,
  output logic [EXT_MEM_W-1:0]  cvt_ext_mem_o,
  // Single and double unpack
  input  wire logic [63:0]      fp_raw_i,
  input  wire logic             fp_dbl_i,
  output logic                  fp_sign_o,
  output logic [10:0]           fp_exp_o,
  output logic [51:0]           fp_frac_o,
  // Bit field and quad integer
  input  wire logic [31:0]      bf_src_i,
  input  wire logic [4:0]       bf_off_i,
  input  wire logic [4:0]       bf_width_i,
  input  wire logic             bf_signed_i,
  output logic [31:0]           bf_o,
  input  wire logic [31:0]      quad_hi_i,
  input  wire logic [31:0]      quad_lo_i,
  output logic [63:0]           quad_o,
  input  wire logic [7:0]       bcd_i,
  output logic [7:0]            bcd_unpk_o
);

  // ********************************************************************
  // Operand formatting (combinational)
  // ********************************************************************
  logic [31:0] cvt_sx;
  logic [31:0] cvt_mag;
  logic [5:0]  cvt_lz;
  logic [31:0] cvt_norm;
  logic [31:0] bf_mask;
  logic [31:0] bf_shift;

  always_comb begin
    // Two's-complement sign extension per size
    unique case (cvt_size_i)
      OFE_SZ_BYTE: cvt_sx = {{24{cvt_int_i[7]}}, cvt_int_i[7:0]};
      OFE_SZ_WORD: cvt_sx = {{16{cvt_int_i[15]}}, cvt_int_i[15:0]};
      default:     cvt_sx = cvt_int_i;
    endcase
    cvt_mag = cvt_sx[31] ? (~cvt_sx + 32'h0000_0001) : cvt_sx;
    cvt_lz  = 6'd32;
    for (int i = 0; i < 32; i++) begin
      if (cvt_mag[i]) begin
        cvt_lz = 6'(31 - i);
      end
    end
    cvt_norm = cvt_mag << cvt_lz[4:0];
    // Exact conversion: every 32-bit integer fits the 64-bit mantissa
    if (cvt_mag == 32'h0000_0000) begin
      cvt_ext_o = {cvt_sx[31], 79'd0};
    end else begin
      cvt_ext_o = {cvt_sx[31], 15'(EXT_BIAS + 31 - int'(cvt_lz)), cvt_norm, 32'd0};
    end
    // Memory image: reserved gap written as zero
    cvt_ext_mem_o = {cvt_ext_o[79:64], 16'h0000, cvt_ext_o[63:0]};
    // IEEE field split
    fp_sign_o = fp_dbl_i ? fp_raw_i[63] : fp_raw_i[31];
    if (fp_dbl_i) begin
      fp_exp_o  = fp_raw_i[62:52];
      fp_frac_o = fp_raw_i[51:0];
    end else begin
      fp_exp_o  = {3'b000, fp_raw_i[30:23]};
      fp_frac_o = {fp_raw_i[22:0], 29'd0};
    end
    // Width 0 encodes 32; field wraps within the long word
    bf_mask  = (bf_width_i == 5'd0) ? 32'hFFFF_FFFF : ((32'h0000_0001 << bf_width_i) - 1);
    bf_shift = (bf_src_i << bf_off_i) | (bf_src_i >> (6'd32 - {1'b0, bf_off_i}));
    bf_shift = (bf_off_i == 5'd0) ? bf_src_i : bf_shift;
    bf_shift = bf_shift >> ((6'd32 - {1'b0, bf_width_i}) & 6'h1F);
    bf_o     = bf_shift & bf_mask;
    if (bf_signed_i && bf_width_i != 5'd0 && bf_o[bf_width_i - 5'd1]) begin
      bf_o = bf_o | ~bf_mask;
    end
    quad_o     = {quad_hi_i, quad_lo_i};
    bcd_unpk_o = {4'h0, bcd_i[3:0]};
  end

  // ********************************************************************
  // Effective-address sequencer
  // ********************************************************************
  typedef enum logic [2:0] {S_IDLE, S_CALC, S_IND, S_OUTER, S_BLK, S_DONE} ofe_state_e;
  ofe_state_e  state,     next_state;
  logic [31:0] addr,      next_addr;
  logic [31:0] ptr,       next_ptr;
  logic [31:0] base_new,  next_base_new;
  logic        base_wr,   next_base_wr;
  logic [31:0] imm,       next_imm;
  logic        align_err, next_align_err;
  logic [31:0] blk_buf [BLOCK_WORDS];
  logic [31:0] next_blk_buf [BLOCK_WORDS];
  logic [2:0]  blk_cnt,   next_blk_cnt;
  logic        blk_wr,    next_blk_wr;
  logic        blk_done,  next_blk_done;
  logic [31:0] blk_src,   next_blk_src;
  logic [31:0] blk_dst,   next_blk_dst;
  logic [31:0] base_sel;
  logic [31:0] idx_val;
  logic [31:0] disp_val;
  logic [31:0] outer_val;
  logic [31:0] step;
  function automatic logic [31:0] ofe_sext(input logic [31:0] v, input logic [1:0] sz);
    unique case (sz)
      2'd0:    return 32'h0000_0000;             // Omitted counts as zero
      2'd1:    return {{24{v[7]}}, v[7:0]};
      2'd2:    return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction : ofe_sext
  always_comb begin
    base_sel  = ea_pc_rel_i ? ea_pc_i : ea_base_i;
    idx_val   = ea_index_long_i ? ea_index_i
                                : {{16{ea_index_i[15]}}, ea_index_i[15:0]};
    idx_val   = ea_index_sup_i ? 32'h0000_0000 : (idx_val << ea_scale_i);
    disp_val  = ofe_sext(ea_disp_i, ea_disp_sz_i);
    outer_val = ofe_sext(ea_outer_i, ea_outer_sz_i);
    unique case (ea_opsize_i)
      OFE_SZ_BYTE: step = 32'h0000_0001;
      OFE_SZ_WORD: step = 32'h0000_0002;
      default:     step = 32'h0000_0004;
    endcase
  end

  always_comb begin
    next_state     = state;
    next_addr      = addr;
    next_ptr       = ptr;
    next_base_new  = base_new;
    next_base_wr   = 1'b0;
    next_imm       = imm;
    next_align_err = align_err;
    next_blk_buf   = blk_buf;
    next_blk_cnt   = blk_cnt;
    next_blk_wr    = blk_wr;
    next_blk_done  = 1'b0;
    next_blk_src   = blk_src;
    next_blk_dst   = blk_dst;
    unique case (state)
      S_IDLE: begin
        if (blk_start_i) begin
          next_align_err = |{blk_src_i[3:0] & BLOCK_ALIGN_MASK,
                             blk_dst_i[3:0] & BLOCK_ALIGN_MASK};
          next_blk_src   = {blk_src_i[31:4], 4'h0};
          next_blk_dst   = {blk_dst_i[31:4], 4'h0};
          next_blk_cnt   = 3'd0;
          next_blk_wr    = 1'b0;
          next_state     = S_BLK;
        end else if (ea_start_i) begin
          next_align_err = 1'b0;
          next_state     = S_CALC;
        end
      end
      S_CALC: begin
        next_state = S_DONE;
        unique case (ea_mode_i)
          OFE_AM_IND:     next_addr = base_sel;
          OFE_AM_POSTINC: begin
            next_addr     = base_sel;
            next_base_new = base_sel + step;
            next_base_wr  = 1'b1;
          end
          OFE_AM_PREDEC: begin
            next_addr     = base_sel - step;
            next_base_new = base_sel - step;
            next_base_wr  = 1'b1;
          end
          OFE_AM_DISP16, OFE_AM_IDX8, OFE_AM_IDXBD:
            next_addr = base_sel + disp_val
                      + ((ea_mode_i == OFE_AM_DISP16) ? 32'h0000_0000 : idx_val);
          OFE_AM_MEM_POST: begin
            next_addr  = base_sel + disp_val;
            next_state = S_IND;
          end
          OFE_AM_MEM_PRE: begin
            next_addr  = base_sel + disp_val + idx_val;
            next_state = S_IND;
          end
          OFE_AM_ABS_W:   next_addr = {{16{ea_ext_word_i[15]}}, ea_ext_word_i[15:0]};
          OFE_AM_ABS_L:   next_addr = ea_ext_word_i;
          default: begin
            unique case (ea_opsize_i)
              OFE_SZ_BYTE: next_imm = {24'd0, ea_ext_word_i[7:0]};
              OFE_SZ_WORD: next_imm = {16'd0, ea_ext_word_i[15:0]};
              default:     next_imm = ea_ext_word_i;
            endcase
          end
        endcase
      end
      S_IND: begin
        if (mem_ack_i) begin
          next_ptr   = mem_rdata_i;
          next_state = S_OUTER;
        end
      end
      S_OUTER: begin
        // Outer term only once the pointer has arrived
        next_addr  = ptr + outer_val
                   + ((ea_mode_i == OFE_AM_MEM_POST) ? idx_val : 32'h0000_0000);
        next_state = S_DONE;
      end
      S_BLK: begin
        if (mem_ack_i) begin
          if (!blk_wr) begin
            next_blk_buf[blk_cnt[1:0]] = mem_rdata_i;
          end
          if (blk_cnt == 3'(BLOCK_WORDS - 1)) begin
            next_blk_cnt = 3'd0;
            next_blk_wr  = ~blk_wr;
            if (blk_wr) begin
              next_blk_done = 1'b1;
              next_state    = S_IDLE;
            end
          end else begin
            next_blk_cnt = blk_cnt + 3'd1;
          end
        end
      end
      S_DONE: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state     <= S_IDLE;
      addr      <= 32'h0000_0000;
      ptr       <= 32'h0000_0000;
      base_new  <= 32'h0000_0000;
      base_wr   <= 1'b0;
      imm       <= 32'h0000_0000;
      align_err <= 1'b0;
      blk_buf   <= '{default: 32'h0000_0000};
      blk_cnt   <= 3'd0;
      blk_wr    <= 1'b0;
      blk_done  <= 1'b0;
      blk_src   <= 32'h0000_0000;
      blk_dst   <= 32'h0000_0000;
    end else begin
      state     <= next_state;
      addr      <= next_addr;
      ptr       <= next_ptr;
      base_new  <= next_base_new;
      base_wr   <= next_base_wr;
      imm       <= next_imm;
      align_err <= next_align_err;
      blk_buf   <= next_blk_buf;
      blk_cnt   <= next_blk_cnt;
      blk_wr    <= next_blk_wr;
      blk_done  <= next_blk_done;
      blk_src   <= next_blk_src;
      blk_dst   <= next_blk_dst;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign ea_busy_o      = (state != S_IDLE);
  assign ea_done_o      = (state == S_DONE);
  assign ea_addr_o      = addr;
  assign ea_base_new_o  = base_new;
  assign ea_base_wr_o   = base_wr;
  assign ea_imm_o       = imm;
  assign ea_align_err_o = align_err;
  assign blk_done_o     = blk_done;
  assign mem_req_o      = (state == S_IND) || (state == S_BLK);
  assign mem_we_o       = (state == S_BLK) && blk_wr;
  // Line is forced to a 16-byte boundary even when misaligned
  assign mem_addr_o     = (state == S_BLK)
                        ? ((blk_wr ? blk_dst : blk_src) + {27'd0, blk_cnt, 2'b00})
                        : addr;
  assign mem_wdata_o    = blk_buf[blk_cnt[1:0]];
endmodule : ofe_datapath

// File: rtl/ofe_pkg.sv
// Package: operand formats, addressing modes and sequencing constants
package ofe_pkg;
  // Operand field layouts
  localparam int unsigned SGL_FRAC_W   = 23;
  localparam int unsigned SGL_EXP_W    = 8;
  localparam int unsigned DBL_FRAC_W   = 52;
  localparam int unsigned DBL_EXP_W    = 11;
  localparam int unsigned EXT_MANT_W   = 64;
  localparam int unsigned EXT_EXP_W    = 15;
  localparam int unsigned EXT_USED_W   = 80;
  localparam int unsigned EXT_MEM_W    = 96;
  localparam int unsigned EXT_RSV_W    = 16;
  localparam int unsigned EXT_BIAS     = 16383;
  localparam int unsigned BLOCK_BYTES  = 16;
  localparam int unsigned BLOCK_WORDS  = 4;
  localparam int unsigned BFLD_MAX_W   = 32;
  localparam logic [3:0]  BLOCK_ALIGN_MASK = 4'hF;

  typedef enum logic [1:0] {OFE_SZ_BYTE, OFE_SZ_WORD, OFE_SZ_LONG} ofe_size_e;

  typedef enum logic [3:0] {
    OFE_AM_IND, OFE_AM_POSTINC, OFE_AM_PREDEC, OFE_AM_DISP16,
    OFE_AM_IDX8, OFE_AM_IDXBD, OFE_AM_MEM_POST, OFE_AM_MEM_PRE,
    OFE_AM_ABS_W, OFE_AM_ABS_L, OFE_AM_IMM
  } ofe_mode_e;
endpackage : ofe_pkg

// File: verif/ofe_mem_model.sv
// Long-word memory partner with random answer delay
`timescale 1ns/1ps
module ofe_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem [64];
  int unsigned wait_cnt;

  initial for (int i = 0; i < 64; i++) mem[i] = 32'hC3A5_0000 ^ (i * 32'h0104_0411);

  // Plain always: the array is also filled by the initial block
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 0;
      rdata_o <= 32'h0000_0000;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      // Stale data inverted so a late sample never matches
      rdata_o <= ~rdata_o;
      wait_cnt <= $urandom_range(3);
    end else if (req_i && wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (req_i) begin
      ack_o <= 1'b1;
      if (we_i) mem[addr_i[7:2]] <= wdata_i;
      else rdata_o <= mem[addr_i[7:2]];
    end
  end
endmodule : ofe_mem_model

// File: verif/ofe_datapath_asserts.sv
// Port checker for the operand datapath
`timescale 1ns/1ps
module ofe_datapath_asserts
  import ofe_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  ea_start_i,
  input wire ofe_mode_e             ea_mode_i,
  input wire logic                  ea_busy_o,
  input wire logic                  ea_done_o,
  input wire logic                  ea_base_wr_o,
  input wire logic                  blk_start_i,
  input wire logic                  mem_req_o,
  input wire logic                  mem_we_o,
  input wire logic                  mem_ack_i,
  input wire logic                  blk_done_o,
  input wire logic [31:0]           cvt_int_i,
  input wire ofe_size_e             cvt_size_i,
  input wire logic [EXT_USED_W-1:0] cvt_ext_o,
  input wire logic [EXT_MEM_W-1:0]  cvt_ext_mem_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ext_rsv; cvt_ext_mem_o[79:64] == 16'h0000; endproperty
  a_ext_rsv: assert property (p_ext_rsv) else $error("ext pad bits set");
  property p_ext_map; cvt_ext_mem_o == {cvt_ext_o[79:64], 16'h0000, cvt_ext_o[63:0]}; endproperty
  a_ext_map: assert property (p_ext_map) else $error("ext image layout");
  property p_cvt_sign;
    cvt_ext_o[79] == cvt_int_i[cvt_size_i == OFE_SZ_BYTE ? 7 : cvt_size_i == OFE_SZ_WORD ? 15 : 31];
  endproperty
  a_cvt_sign: assert property (p_cvt_sign) else $error("convert sign");
  property p_cvt_norm; cvt_ext_o[63] == (cvt_ext_o[78:64] != 15'h0000); endproperty
  a_cvt_norm: assert property (p_cvt_norm) else $error("convert not normalised");
  property p_simple_lat;
    ea_start_i && !ea_busy_o && !blk_start_i && !(ea_mode_i inside {OFE_AM_MEM_POST, OFE_AM_MEM_PRE})
    |=> !ea_done_o ##1 ea_done_o ##1 !ea_done_o;
  endproperty
  a_simple_lat: assert property (p_simple_lat) else $error("address latency");
  property p_ind_req;
    ea_start_i && !ea_busy_o && !blk_start_i && ea_mode_i inside {OFE_AM_MEM_POST, OFE_AM_MEM_PRE}
    |=> !ea_done_o ##1 (mem_req_o && !mem_we_o);
  endproperty
  a_ind_req: assert property (p_ind_req) else $error("pointer read missing");
  property p_base_wr; ea_base_wr_o |-> ea_done_o && ea_mode_i inside {OFE_AM_POSTINC, OFE_AM_PREDEC};
  endproperty
  a_base_wr: assert property (p_base_wr) else $error("base update misplaced");
  property p_blk_done; blk_done_o |-> $past(mem_ack_i && mem_we_o) ##1 !blk_done_o; endproperty
  a_blk_done: assert property (p_blk_done) else $error("block done misplaced");
endmodule : ofe_datapath_asserts

bind ofe_datapath ofe_datapath_asserts u_chk (.*);

// File: verif/tb_top.sv
// Self-checking bench for the operand datapath
`timescale 1ns/1ps
module tb_top
  import ofe_pkg::*;
;
  logic clk_i, rst_i, ea_start_i, ea_pc_rel_i, ea_index_long_i, ea_index_sup_i, mem_ack_i;
  logic blk_start_i, fp_dbl_i, bf_signed_i, ea_busy_o, ea_done_o, ea_base_wr_o, ea_align_err_o;
  logic mem_req_o, mem_we_o, blk_done_o, fp_sign_o;
  logic [1:0] ea_scale_i, ea_disp_sz_i, ea_outer_sz_i;
  logic [4:0] bf_off_i, bf_width_i;
  logic [7:0] bcd_i, bcd_unpk_o;
  logic [10:0] fp_exp_o;
  logic [51:0] fp_frac_o;
  logic [63:0] fp_raw_i, quad_o;
  logic [79:0] cvt_ext_o;
  logic [95:0] cvt_ext_mem_o;
  logic [31:0] ea_base_i, ea_pc_i, ea_index_i, ea_disp_i, ea_outer_i, ea_ext_word_i, ea_addr_o;
  logic [31:0] ea_base_new_o, ea_imm_o, mem_addr_o, mem_wdata_o, mem_rdata_i, blk_src_i;
  logic [31:0] blk_dst_i, cvt_int_i, bf_src_i, bf_o, quad_hi_i, quad_lo_i;
  ofe_mode_e ea_mode_i;
  ofe_size_e ea_opsize_i, cvt_size_i;
  int miscompares, n_compared;

  ofe_datapath dut (.*);
  ofe_mem_model u_mem (.clk_i, .rst_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // ***
  // Expectations and checks
  // ***
  function automatic logic [31:0] sx(logic [31:0] v, logic [1:0] sz);
    return sz == 2'd0 ? 32'h0 : sz == 2'd1 ? {{24{v[7]}}, v[7:0]}
         : sz == 2'd2 ? {{16{v[15]}}, v[15:0]} : v;
  endfunction : sx

  function automatic logic [79:0] to_ext(logic [31:0] v, logic [1:0] sz);
    logic [31:0] s;
    logic [63:0] m;
    logic [14:0] e;
    s = sx(v, sz + 2'd1);
    if (s == 32'h0) return 80'h0;
    m = {s[31] ? -s : s, 32'h0};
    e = 15'(EXT_BIAS + 31);
    while (!m[63]) begin
      m = m << 1;
      e = e - 15'h1;
    end
    return {s[31], e, m};
  endfunction : to_ext

  function automatic logic [31:0] bf_exp(logic [31:0] s, logic [4:0] o, logic [4:0] w, logic g);
    int n;
    n = (w == 0) ? 32 : int'(w);
    s = s << o;
    return g ? 32'($signed(s) >>> (32 - n)) : s >> (32 - n);
  endfunction : bf_exp

  function automatic logic [31:0] ea_exp(output logic [31:0] mid);
    logic [31:0] b, d, x, o, p;
    b = ea_pc_rel_i ? ea_pc_i : ea_base_i;
    d = sx(ea_disp_i, ea_disp_sz_i);
    o = sx(ea_outer_i, ea_outer_sz_i);
    x = ea_index_sup_i ? 32'h0 : (ea_index_long_i ? ea_index_i : sx(ea_index_i, 2'd2)) << ea_scale_i;
    mid = b + d + (ea_mode_i == OFE_AM_MEM_PRE ? x : 32'h0);
    p = u_mem.mem[mid[7:2]];
    case (ea_mode_i)
      OFE_AM_PREDEC:              return b - (32'h1 << ea_opsize_i);
      OFE_AM_IND, OFE_AM_POSTINC: return b;
      OFE_AM_DISP16:              return b + d;
      OFE_AM_IDX8, OFE_AM_IDXBD:  return b + d + x;
      OFE_AM_MEM_POST:            return p + x + o;
      OFE_AM_MEM_PRE:             return p + o;
      OFE_AM_ABS_W:               return sx(ea_ext_word_i, 2'd2);
      default:                    return ea_ext_word_i;
    endcase
  endfunction : ea_exp

  task automatic chk(string what, logic [95:0] seen, logic [95:0] want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic ea_run();
    logic [31:0] mid, want, ma, step;
    int n;
    want = ea_exp(mid);
    step = 32'h1 << ea_opsize_i;
    ma = 32'h0;
    n = 0;
    ea_start_i = 1'b1;
    @(negedge clk_i);
    ea_start_i = 1'b0;
    chk("busy", ea_busy_o, 1'b1);
    while (ea_done_o !== 1'b1 && n < 50) begin
      if (mem_req_o === 1'b1) ma = mem_addr_o;
      @(negedge clk_i);
      n++;
    end
    if (ea_done_o !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    if (ea_mode_i == OFE_AM_IMM)
      chk("imm", ea_imm_o, ea_ext_word_i & ~(32'hFFFF_FFFF << (8 << ea_opsize_i)));
    else
      chk("addr", ea_addr_o, want);
    if (ea_mode_i inside {OFE_AM_MEM_POST, OFE_AM_MEM_PRE}) chk("ptr", ma, mid);
    chk("base_wr", ea_base_wr_o, ea_mode_i inside {OFE_AM_POSTINC, OFE_AM_PREDEC});
    if (ea_mode_i inside {OFE_AM_POSTINC, OFE_AM_PREDEC})
      chk("base_new", ea_base_new_o, ea_mode_i == OFE_AM_PREDEC ? want : want + step);
    // Spare cycle: start on the done edge may be refused
    @(negedge clk_i);
    chk("idle", ea_busy_o, 1'b0);
  endtask : ea_run

  task automatic blk_run(logic [31:0] src, logic [31:0] dst);
    logic [31:0] w [4];
    int n;
    for (int i = 0; i < 4; i++) w[i] = u_mem.mem[{src[7:4], 2'(i)}];
    blk_src_i = src;
    blk_dst_i = dst;
    blk_start_i = 1'b1;
    @(negedge clk_i);
    blk_start_i = 1'b0;
    n = 0;
    while (blk_done_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    if (blk_done_o !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    chk("align_err", ea_align_err_o, |{src[3:0], dst[3:0]});
    for (int i = 0; i < 4; i++) chk("blk_word", u_mem.mem[{dst[7:4], 2'(i)}], w[i]);
    @(negedge clk_i);
  endtask : blk_run

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    logic [79:0] e;
    {ea_start_i, ea_pc_rel_i, ea_index_long_i, ea_index_sup_i, blk_start_i, fp_dbl_i, bf_signed_i,
     ea_scale_i, ea_disp_sz_i, ea_outer_sz_i, bf_off_i, bf_width_i, bcd_i, fp_raw_i, ea_base_i,
     ea_pc_i, ea_index_i, ea_disp_i, ea_outer_i, ea_ext_word_i, blk_src_i, blk_dst_i, cvt_int_i,
     bf_src_i, quad_hi_i, quad_lo_i} = '0;
    ea_mode_i = OFE_AM_IND;
    ea_opsize_i = OFE_SZ_LONG;
    cvt_size_i = OFE_SZ_LONG;
    rst_i = 1'b1;
    void'($urandom(32'h84c1));
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 40; i++) begin
      cvt_int_i = i == 0 ? 32'h0 : i == 1 ? 32'h8000_0000 : $urandom();
      cvt_size_i = ofe_size_e'(i < 2 ? 2 : i % 3);
      fp_raw_i = {$urandom(), $urandom()};
      fp_dbl_i = i[0];
      quad_hi_i = $urandom();
      quad_lo_i = $urandom();
      bcd_i = 8'($urandom());
      bf_src_i = $urandom();
      bf_width_i = 5'($urandom());
      bf_off_i = 5'($urandom_range(bf_width_i == 0 ? 0 : 32 - bf_width_i));
      bf_signed_i = 1'($urandom());
      #1;
      e = to_ext(cvt_int_i, cvt_size_i);
      chk("cvt_ext", cvt_ext_o, e);
      chk("ext_mem", cvt_ext_mem_o, {e[79:64], 16'h0000, e[63:0]});
      if (fp_dbl_i) chk("fp_dbl", {fp_sign_o, fp_exp_o, fp_frac_o}, fp_raw_i);
      else chk("fp_sgl", {fp_sign_o, fp_exp_o[7:0], fp_frac_o[51:29]}, fp_raw_i[31:0]);
      chk("quad", quad_o, {quad_hi_i, quad_lo_i});
      chk("bcd", bcd_unpk_o, {4'h0, bcd_i[3:0]});
      chk("bfield", bf_o, bf_exp(bf_src_i, bf_off_i, bf_width_i, bf_signed_i));
      @(negedge clk_i);
    end
    $display("test formats done");
    for (int i = 0; i < 66; i++) begin
      ea_mode_i = ofe_mode_e'(i % 11);
      ea_opsize_i = ofe_size_e'($urandom_range(2));
      {ea_base_i, ea_pc_i, ea_index_i, ea_disp_i} = {$urandom(), $urandom(), $urandom(), $urandom()};
      {ea_outer_i, ea_ext_word_i} = {$urandom(), $urandom()};
      {ea_index_long_i, ea_scale_i} = 3'($urandom());
      ea_outer_sz_i = i[2] ? {1'b1, i[0]} : 2'd0;
      ea_index_sup_i = ea_mode_i inside {OFE_AM_IDXBD, OFE_AM_MEM_POST, OFE_AM_MEM_PRE} && i[4];
      ea_pc_rel_i = ea_mode_i inside {[OFE_AM_DISP16:OFE_AM_MEM_PRE]} && i[3];
      ea_disp_sz_i = ea_mode_i == OFE_AM_DISP16 ? 2'd2 : ea_mode_i == OFE_AM_IDX8 ? 2'd1
                   : (i % 3 == 1) ? 2'd3 : 2'(i % 3);
      // Pointer tables live in the low 256 bytes of the model
      if (ea_mode_i inside {OFE_AM_MEM_POST, OFE_AM_MEM_PRE}) begin
        ea_base_i = 32'h40 + (32'($urandom_range(7)) << 2);
        ea_pc_i = ea_base_i;
        ea_disp_i = 32'($urandom_range(7)) << 2;
        ea_index_i = 32'($urandom_range(3)) << 2;
        ea_scale_i = 2'd0;
      end
      ea_run();
    end
    $display("test address done");
    blk_run(32'h0000_0000, 32'h0000_0080);
    blk_run(32'h0000_0047, 32'h0000_00C2);
    $display("test block done");
    end_of_test();
  end
endmodule : tb_top
